//--- bank_ram.sv
`timescale 1ns/100ps
module bank_ram #(
    parameter int WIDTH = 32,
    parameter int DEPTH_W = 12
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [DEPTH_W-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [DEPTH_W-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    // Plain storage array; contents are left unreset on purpose, as host
    // software always loads it with the store switched off.
    logic [WIDTH-1:0] mem [0:(1<<DEPTH_W)-1];

    // Synchronous write port.
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port, so data reaches the sequencer from a flip-flop.
    always_ff @(posedge core_clk) begin
        rdata <= mem[raddr];
    end
endmodule

//--- control_store_bank_mapper.sv
`timescale 1ns/100ps
// How it works
// - The 16k microcode space is sixteen 1k modules numbered 0 to 15.
// - Only the upper 8k of the space may be served from this card.
// - Four physical banks 0 to 3 hold 4k microwords on the card.
// - A sixteen-entry map holds one entry per logical module.
// - An entry names the bank enabled for that module, or marks it unmapped.
// - A responding card disables lower cards and the processor's own store.
// - The module number is address bits 13:10; module 4 is 1000 to 13FF.
// - Host can switch the store on and read back that it is on.
// - Host can switch the store off and read back that it is off.
module control_store_bank_mapper (
    input wire logic core_clk,
    input wire logic resetn,
    // Sequencer side.
    input wire logic seq_valid,
    input wire logic [store_map_pkg::ADDR_W-1:0] seq_addr,
    input wire logic upstream_disable,
    output logic [store_map_pkg::DATA_W-1:0] ustore_data,
    output logic ustore_data_oe,
    output logic downstream_disable,
    // Host side of the card's I/O location.
    input wire logic host_store_on,
    input wire logic host_store_off,
    input wire logic host_map_clear,
    input wire logic host_map_we,
    input wire logic [store_map_pkg::MODULE_W-1:0] host_map_module,
    input wire logic [store_map_pkg::BANK_W-1:0] host_map_bank,
    input wire logic host_map_valid,
    input wire logic host_ram_we,
    input wire logic host_ram_re,
    input wire logic [store_map_pkg::ADDR_W-1:0] host_ram_addr,
    input wire logic [store_map_pkg::DATA_W-1:0] host_ram_wdata,
    output logic [store_map_pkg::DATA_W-1:0] host_ram_rdata,
    output logic host_ram_rvalid,
    output logic host_ram_err,
    output logic [store_map_pkg::ENTRY_W-1:0] host_map_rdata,
    output logic store_on_status
);
    import store_map_pkg::*;

    logic store_on_r;
    logic [ENTRY_W-1:0] map_r [0:NUM_MODULES-1];
    host_state_type host_state_r;
    logic [ENTRY_W-1:0] seq_entry;
    logic seq_hit;
    logic seq_hit_r;
    logic [ENTRY_W-1:0] host_entry;
    logic host_hit;
    logic host_access_ok;
    logic ram_we;
    logic [CARD_ADDR_W-1:0] ram_waddr;
    logic [CARD_ADDR_W-1:0] ram_raddr;
    logic [DATA_W-1:0] ram_rdata;
    logic host_is_write;
    logic downstream_disable_upstream_r;

    // Splits an address into its module number.
    function automatic logic [MODULE_W-1:0] module_of(
        input logic [ADDR_W-1:0] addr
    );
        module_of = addr[ADDR_W-1:OFFSET_W];
    endfunction

    // Forms the card-local word address from a map entry and an address.
    function automatic logic [CARD_ADDR_W-1:0] card_addr(
        input logic [ENTRY_W-1:0] entry,
        input logic [ADDR_W-1:0] addr
    );
        card_addr = {entry[BANK_W-1:0], addr[OFFSET_W-1:0]};
    endfunction

    // Only addresses in the user half of the space may be served from here.
    function automatic logic user_range(
        input logic [ADDR_W-1:0] addr
    );
        user_range = (addr >= USER_BASE) && (addr <= USER_LIMIT);
    endfunction

    // Store on/off state; off after reset so nothing answers unloaded.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            store_on_r <= STORE_ON_RESET;
        end else if (host_store_off || host_map_clear) begin
            store_on_r <= 1'b0;
        end else if (host_store_on) begin
            store_on_r <= 1'b1;
        end
    end

    assign store_on_status = store_on_r;

    // Map entries; writes are accepted only while the store is off, which
    // keeps the sequencer from seeing a half-changed mapping.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MODULES; gi++) begin : g_map
            always_ff @(posedge core_clk) begin
                if (!resetn || host_map_clear) begin
                    map_r[gi] <= ENTRY_UNMAPPED;
                end else if (host_map_we && !store_on_r &&
                             host_map_module == MODULE_W'(gi)) begin
                    map_r[gi] <= {host_map_valid, host_map_bank};
                end
            end
        end
    endgenerate

    // Readback of the addressed map entry for the host.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            host_map_rdata <= ENTRY_UNMAPPED;
        end else begin
            host_map_rdata <= map_r[host_map_module];
        end
    end

    // Sequencer lookup: the card answers only for mapped user modules.
    assign seq_entry = map_r[module_of(seq_addr)];
    assign seq_hit = seq_valid && store_on_r && user_range(seq_addr)
                     && seq_entry[ENTRY_VALID_BIT];

    // Host lookup for data RAM access.
    assign host_entry = map_r[module_of(host_ram_addr)];
    assign host_hit = host_entry[ENTRY_VALID_BIT];
    assign host_access_ok = host_hit && !store_on_r;

    // The host owns the RAM port while the store is off.
    assign ram_we = host_ram_we && host_access_ok && host_state_r == HOST_IDLE;
    assign ram_waddr = card_addr(host_entry, host_ram_addr);
    assign ram_raddr = store_on_r ? card_addr(seq_entry, seq_addr)
                                  : card_addr(host_entry, host_ram_addr);

    bank_ram #(
        .WIDTH(DATA_W),
        .DEPTH_W(CARD_ADDR_W)
    ) u_banks (
        .core_clk(core_clk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(host_ram_wdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    // Hit is delayed to line up with the registered RAM read.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            seq_hit_r <= 1'b0;
        end else begin
            seq_hit_r <= seq_hit;
        end
    end

    // A higher card wins; this card yields and forwards the disable so the
    // processor store stays quiet too.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            downstream_disable <= 1'b0;
        end else begin
            downstream_disable <= upstream_disable || seq_hit;
        end
    end

    // Data only drives while this card is the chosen responder.
    assign ustore_data_oe = seq_hit_r && !downstream_disable_upstream_r;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            downstream_disable_upstream_r <= 1'b0;
        end else begin
            downstream_disable_upstream_r <= upstream_disable;
        end
    end

    // Data output is combinationally forced to zero whenever the card does not answer.
    always_comb begin
        ustore_data = ustore_data_oe ? ram_rdata : '0;
    end

    // Host access sequencing: one cycle to issue, one to return data.
    assign host_is_write = host_ram_we;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            host_state_r <= HOST_IDLE;
        end else begin
            case (host_state_r)
                HOST_IDLE: begin
                    if (host_ram_re && !host_is_write) begin
                        host_state_r <= HOST_READ;
                    end
                end
                HOST_READ: begin
                    host_state_r <= HOST_DONE;
                end
                HOST_DONE: begin
                    host_state_r <= HOST_IDLE;
                end
                default: begin
                    host_state_r <= HOST_IDLE;
                end
            endcase
        end
    end

    // Error flags an access to an unmapped module or with the store on.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            host_ram_err <= 1'b0;
        end else if ((host_ram_we || host_ram_re) &&
                     host_state_r == HOST_IDLE) begin
            host_ram_err <= !host_access_ok;
        end
    end

    // Read data register; it holds the last good read.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            host_ram_rdata <= '0;
            host_ram_rvalid <= 1'b0;
        end else begin
            host_ram_rvalid <= (host_state_r == HOST_READ) && !host_ram_err;
            if (host_state_r == HOST_READ && !host_ram_err) begin
                host_ram_rdata <= ram_rdata;
            end
        end
    end
endmodule

//--- control_store_bank_mapper_tb_top.sv
`timescale 1ns/100ps
module control_store_bank_mapper_tb_top;
    import store_map_pkg::*;
    logic core_clk, resetn, seq_valid, upstream_disable, ustore_data_oe;
    logic downstream_disable, host_store_on, host_store_off, host_map_clear;
    logic host_map_we, host_map_valid, host_ram_we, host_ram_re;
    logic host_ram_rvalid, host_ram_err, store_on_status;
    logic [MODULE_W-1:0] host_map_module;
    logic [BANK_W-1:0] host_map_bank;
    logic [ADDR_W-1:0] seq_addr, host_ram_addr;
    logic [DATA_W-1:0] ustore_data, host_ram_wdata, host_ram_rdata;
    logic [ENTRY_W-1:0] host_map_rdata;
    int errors, tests_run;
    control_store_bank_mapper control_store_bank_mapper_inst (.*);
    sequencer_model sequencer_model_inst (.*);
    // Half period of 2 ns gives the 250 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Stimulus always moves 1 ns after a rising edge, clear of sampling.
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [DATA_W:0] seen, input logic [DATA_W:0] x);
        tests_run++;
        if (seen !== x) begin
            errors++;
            $display("Error at %0t: seen %h, expected %h", $time, seen, x);
        end
    endtask
    task automatic complete_run();
        $display("%0d checks, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Host pulses in order: store on, store off, map clear, map write.
    task automatic pulse(input logic [3:0] p);
        step();
        {host_store_on, host_store_off, host_map_clear, host_map_we} = p;
        step();
        {host_store_on, host_store_off, host_map_clear, host_map_we} = 4'h0;
    endtask
    task automatic map_set(input logic [3:0] m, input logic [2:0] e);
        {host_map_module, host_map_valid, host_map_bank} = {m, e};
        pulse(4'h1);
    endtask
    task automatic ram(input logic we, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        step();
        {host_ram_we, host_ram_re} = {we, !we};
        {host_ram_addr, host_ram_wdata} = {a, d};
        step();
        {host_ram_we, host_ram_re} = 2'h0;
    endtask
    // Disable and data both answer the cycle after the fetch is taken.
    // The data stands for that one cycle only.
    task automatic ask(input logic [ADDR_W-1:0] a, input logic up,
        input logic hit, input logic [DATA_W-1:0] d);
        sequencer_model_inst.issue(a, up);
        chk(downstream_disable, hit | up);
        chk({ustore_data_oe, ustore_data}, {hit, d});
        step();
        chk(ustore_data_oe, 1'b0);
    endtask
    // Clear, map three modules, load two banks, refuse an unmapped one.
    task automatic t_load();
        chk(store_on_status, 1'b0);
        pulse(4'h2);
        map_set(4'h8, 3'h6);
        map_set(4'hC, 3'h7);
        map_set(4'h4, 3'h5);
        step();
        chk(host_map_rdata, 3'h5);
        ram(1'b1, 14'h2005, 32'hA5A5_0001);
        ram(1'b1, 14'h33FF, 32'h5A5A_0002);
        chk(host_ram_err, 1'b0);
        ram(1'b1, 14'h2400, 32'h0000_0009);
        chk(host_ram_err, 1'b1);
        ram(1'b0, 14'h2005, 32'h0);
        step();
        chk({host_ram_rvalid, host_ram_rdata}, {1'b1, 32'hA5A5_0001});
        $display("load test done");
    endtask
    // Hits and misses with the store on, then a fetch once it is off.
    task automatic t_fetch();
        pulse(4'h8);
        chk(store_on_status, 1'b1);
        map_set(4'h8, 3'h5);
        step();
        chk(host_map_rdata, 3'h6);
        ram(1'b1, 14'h2005, 32'h0);
        chk(host_ram_err, 1'b1);
        ask(14'h2005, 1'b0, 1'b1, 32'hA5A5_0001);
        ask(14'h33FF, 1'b0, 1'b1, 32'h5A5A_0002);
        ask(14'h3400, 1'b0, 1'b0, 32'h0);
        ask(14'h1000, 1'b0, 1'b0, 32'h0);
        ask(14'h2005, 1'b1, 1'b0, 32'h0);
        pulse(4'h4);
        chk(store_on_status, 1'b0);
        ask(14'h2005, 1'b0, 1'b0, 32'h0);
        pulse(4'h2);
        step();
        chk(host_map_rdata, 3'h0);
        $display("fetch test done");
    endtask
    initial begin
        {resetn, host_store_on, host_store_off, host_map_clear} = 4'h0;
        {host_map_we, host_map_valid, host_ram_we, host_ram_re} = 4'h0;
        {host_map_module, host_map_bank, host_ram_addr} = '0;
        host_ram_wdata = '0;
        errors = 0;
        tests_run = 0;
        repeat (8) step();
        resetn = 1'b1;
        t_load();
        t_fetch();
        complete_run();
    end
endmodule

//--- sequencer_model.sv
`timescale 1ns/100ps
module sequencer_model (
    input wire logic core_clk,
    output logic seq_valid,
    output logic [store_map_pkg::ADDR_W-1:0] seq_addr,
    output logic upstream_disable
);
    import store_map_pkg::*;
    initial {seq_valid, seq_addr, upstream_disable} = '0;
    // One cycle per address; the released bus shows the inverse, not a copy.
    task automatic issue(input logic [ADDR_W-1:0] a, input logic up);
        @(posedge core_clk);
        #1;
        {seq_valid, seq_addr, upstream_disable} = {1'b1, a, up};
        @(posedge core_clk);
        #1;
        {seq_valid, seq_addr, upstream_disable} = {1'b0, ~a, 1'b0};
    endtask
endmodule

//--- store_map_checker.sv
`timescale 1ns/100ps
module store_map_checker
    import store_map_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic seq_valid,
    input wire logic [ADDR_W-1:0] seq_addr,
    input wire logic upstream_disable,
    input wire logic [DATA_W-1:0] ustore_data,
    input wire logic ustore_data_oe,
    input wire logic downstream_disable,
    input wire logic host_store_on,
    input wire logic host_store_off,
    input wire logic host_map_clear,
    input wire logic store_on_status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Fetches aimed at this card, and the two store switch requests.
    wire ask = seq_valid && !upstream_disable;
    wire on_req = host_store_on && !host_store_off && !host_map_clear;
    wire off_req = host_store_off || host_map_clear;
    // A refused fetch: neither disable nor data in the following cycle.
    sequence s_quiet; !downstream_disable && !ustore_data_oe; endsequence
    property p_off; ask && !store_on_status |=> s_quiet; endproperty
    a_off: assert property (p_off) else $error("answer while off");
    property p_low; ask && seq_addr < USER_BASE |=> s_quiet; endproperty
    a_low: assert property (p_low) else $error("answer below 8k");
    property p_up; upstream_disable |=> downstream_disable; endproperty
    a_up: assert property (p_up) else $error("disable lost");
    property p_upd; seq_valid && upstream_disable |=> !ustore_data_oe;
    endproperty
    a_upd: assert property (p_upd) else $error("lower card drove");
    property p_oe; ustore_data_oe |-> downstream_disable; endproperty
    a_oe: assert property (p_oe) else $error("data, no disable");
    property p_zero; !ustore_data_oe |-> ustore_data == '0; endproperty
    a_zero: assert property (p_zero) else $error("data not idle");
    property p_on; on_req |=> store_on_status; endproperty
    a_on: assert property (p_on) else $error("store not on");
    property p_offs; off_req |=> !store_on_status; endproperty
    a_offs: assert property (p_offs) else $error("store not off");
endmodule
bind control_store_bank_mapper store_map_checker store_map_checker_inst (.*);

//--- store_map_pkg.sv
package store_map_pkg;
    // Microcode address space: 16k words in sixteen 1k modules.
    localparam int ADDR_W = 14;
    localparam int MODULE_W = 4;
    localparam int NUM_MODULES = 16;
    localparam int OFFSET_W = 10;
    // Four physical banks per card, 4k words in all.
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int CARD_ADDR_W = 12;
    localparam int DATA_W = 32;
    // User microcode may occupy only the upper 8k of the space.
    localparam logic [ADDR_W-1:0] USER_BASE = 14'h2000;
    localparam logic [ADDR_W-1:0] USER_LIMIT = 14'h3FFF;
    // Map entry layout: bit 2 marks the module mapped, bits 1:0 the bank.
    localparam int ENTRY_W = 3;
    localparam int ENTRY_VALID_BIT = 2;
    localparam logic [ENTRY_W-1:0] ENTRY_UNMAPPED = 3'h0;
    localparam logic STORE_ON_RESET = 1'b0;
    // Host access cycle states.
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_READ = 2'b01,
        HOST_DONE = 2'b10
    } host_state_type;
endpackage
